// >>> core/dpl_pkg.sv
// Constants, register map and carrier types of the digital PLL phase/bandwidth control block.
// What this block does
// - Loop logic runs from a 204.8 MHz clock multiplied from 12.800 MHz.
// - Output edges are placed with one core clock cycle, 4.9 ns, granularity.
// - Main loop has acquisition and locked bandwidths, ten steps 0.1 Hz to 70 Hz.
// - Damping factor selects among 1.2, 2.5, 5, 10 and 20.
// - Input-to-output phase offset up to +-32767 steps of 6 ps, a little short of +-200 ns.
// - Holdover averaging of about 8 or 110 minutes, averaged value readable.
// - Auxiliary loop bandwidth is only 18 Hz, 35 Hz or 70 Hz.
// - Automatic selection picks bandwidth by lock state; otherwise locked setting only.
// - Phase detector accepts 2 kHz up to 77.76 MHz inputs.
// - Eight-kilohertz option bit 6 divides that input to 8 kHz first.
// - Nearest-edge locking starts on phase lock when multi-cycle detector is off.
// - General configuration bit 6 set forbids nearest-edge locking.
// - Nearest-edge capture is +-180 degrees, normal is +-360 degrees.
// - Multi-cycle detector enabled by bit 6, range 1, 3, 7 ... 8191 UI.
// - Bit 5 high feeds full multi-cycle phase, low limits to 360 degrees.
// - Multi-cycle detector always tracks accumulated phase when enabled.
// - Phase loss from four enabled sources: fine, coarse, frequency limit, inactivity.
// - Lock state picks nearest-edge use and bandwidth; acquisition while unlocked under automatic selection.
// - Coarse detector flags n whole cycles, n from the multi-cycle range bits.
// - Frequency acceptance range programmable from 0 to 80 ppm.
// - Registers 6A to 6D weight the phase/frequency and early/late detectors.
// - Phase buildout absorbs source-switch phase steps, residual down to +-5 ns.
// - Over 100 s in lost-phase disqualifies the reference and raises an alarm.
package dpl_pkg;
	localparam longint CLK_HZ = 25_000_000;
	localparam longint OSC_KHZ = 12_800;
	localparam longint CORE_KHZ = 204_800;
	localparam longint EDGE_STEP_PS = 4_900;
	localparam longint OFS_STEP_PS = 6;
	localparam longint OFS_MAX_NS = 200;
	localparam logic [15:0] OFS_MAX = 16'(OFS_MAX_NS * 1000 / OFS_STEP_PS);
	localparam longint LOST_TIME_S = 100;
	localparam longint LOST_CYCLES = LOST_TIME_S * CLK_HZ;
	localparam longint AVG_TICK_US = 1000;
	localparam longint AVG_TICK_CYCLES = AVG_TICK_US * CLK_HZ / 1_000_000;
	localparam int FAST_SHIFT = 19;
	localparam int SLOW_SHIFT = 23;
	localparam logic [7:0] A_GEN = 8'h03;
	localparam logic [7:0] A_STS = 8'h0f;
	localparam logic [7:0] A_IN0 = 8'h22;
	localparam logic [7:0] A_IN1 = 8'h23;
	localparam logic [7:0] A_IN2 = 8'h27;
	localparam logic [7:0] A_IN3 = 8'h28;
	localparam logic [7:0] A_AUTOBW = 8'h3b;
	localparam logic [7:0] A_HOFS_L = 8'h3e;
	localparam logic [7:0] A_HOFS_M = 8'h3f;
	localparam logic [7:0] A_HMODE = 8'h40;
	localparam logic [7:0] A_LOSS2 = 8'h4d;
	localparam logic [7:0] A_LKBW = 8'h67;
	localparam logic [7:0] A_ACQBW = 8'h69;
	localparam logic [7:0] A_WT0 = 8'h6a;
	localparam logic [7:0] A_DAMP = 8'h6b;
	localparam logic [7:0] A_LOSS1 = 8'h73;
	localparam logic [7:0] A_MC = 8'h74;
	localparam logic [7:0] A_OFS_L = 8'h7a;
	localparam logic [7:0] A_OFS_H = 8'h7b;
	localparam logic [7:0] A_AUXBW = 8'h7c;
	localparam logic [7:0] A_FRANGE = 8'h7d;
	localparam logic [7:0] A_FTOL = 8'h7e;
	localparam logic [7:0] A_DIV = 8'h7f;
	localparam int B_NE_DIS = 6;
	localparam int B_EIGHT_KHZ_DIVIDED_LOCK = 6;
	localparam int B_AUTOBW = 0;
	localparam int B_FAST = 6;
	localparam int B_RDAVG = 5;
	localparam int B_MC_EN = 6;
	localparam int B_MC_FULL = 5;
	localparam int B_COARSE_EN = 7;
	localparam int B_FINE_EN = 0;
	localparam int B_LIMIT_EN = 0;
	localparam int B_ACT_EN = 1;
	localparam int B_CLR_DISQ = 3;
	localparam int B_CLR_ALARM = 4;
	localparam logic [3:0] BW_STEPS = 4'd10;
	localparam logic [2:0] DAMP_MIN = 3'd1;
	localparam logic [2:0] DAMP_MAX = 3'd5;
	localparam logic [1:0] AUX_STEPS = 2'd3;
	localparam logic [3:0] MC_RNG_MAX = 4'd12;
	localparam logic [6:0] FRANGE_MAX = 7'd80;
	localparam logic [3:0] RST_LK_BW = 4'd4;
	localparam logic [3:0] RST_ACQ_BW = 4'd7;
	localparam logic [2:0] RST_DAMP = 3'd3;
	localparam logic [7:0] RST_WT = 8'h40;
	localparam logic [6:0] RST_FRANGE = 7'd9;
	localparam logic [7:0] RST_FTOL = 8'h08;
	localparam logic [7:0] RST_DIV = 8'h00;
	localparam logic [6:0] FINE_SAT = 7'h7f;

	typedef struct packed {
		logic [3:0] bw_sel;
		logic [1:0] aux_bw;
		logic [2:0] damping;
		logic nearest_edge;
		logic [6:0] freq_range;
		logic signed [15:0] phase_offset;
		logic [31:0] det_weight;
	} dpl_ctl_t;

	typedef struct packed {
		logic locked;
		logic lost;
		logic disqualify;
		logic alarm;
		logic signed [21:0] loop_phase;
	} dpl_sts_t;

	typedef struct packed {
		logic ne_dis;
		logic [3:0] in_8k;
		logic auto_bw;
		logic [3:0] lk_bw;
		logic [3:0] acq_bw;
		logic [31:0] wt;
		logic [2:0] damp;
		logic fast;
		logic rdavg;
		logic [18:0] hofs;
		logic [3:0] loss_en;
		logic mc_en;
		logic mc_full;
		logic [3:0] mc_rng;
		logic [1:0] aux_bw;
		logic signed [15:0] ofs;
		logic [6:0] frange;
		logic [7:0] ftol;
		logic [7:0] div;
		logic [7:0] div_cnt;
		logic [1:0] sel_q;
		logic ph_run;
		logic ph_dir;
		logic [6:0] ph_cnt;
		logic signed [7:0] fine;
		logic signed [7:0] phase_buildout;
		logic signed [13:0] cyc;
		logic [31:0] tmr;
		logic [14:0] tick_cnt;
		logic signed [42:0] acc;
		logic [7:0] rdata;
		dpl_ctl_t ctl;
		dpl_sts_t sts;
	} dpl_st_t;
endpackage

// >>> core/dpl_core.sv
// Phase detectors, lock/loss detection and bandwidth control of the main digital PLL.
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module dpl_core
	import dpl_pkg::*;
#(
	parameter logic [31:0] LOST_LIMIT = 32'(LOST_CYCLES),
	parameter logic [14:0] AVG_TICK = 15'(AVG_TICK_CYCLES)
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [1:0] ref_sel,
	input wire logic ref_edge,
	input wire logic fb_edge,
	input wire logic [18:0] cur_freq,
	input wire logic at_freq_limit,
	input wire logic input_active,
	output dpl_ctl_t ctl,
	output dpl_sts_t sts
);

////////////////////////////////////////////////////////////////////////////////

dpl_st_t s;
dpl_st_t next_s;

assign reg_rdata = s.rdata;
assign ctl = s.ctl;
assign sts = s.sts;

////////////////////////////////////////////////////////////////////////////////

always_comb begin
	logic ref_e;
	logic [15:0] lim_w;
	logic signed [13:0] lim;
	logic signed [7:0] fine_abs;
	logic signed [13:0] cyc_abs;
	logic signed [8:0] resid;
	logic [3:0] src;
	logic lost;
	logic signed [42:0] fx;
	logic [18:0] avg;
	int sh;
	next_s = s;
	ref_e = 1'b0;
	lim_w = '0;
	lim = '0;
	fine_abs = '0;
	cyc_abs = '0;
	resid = '0;
	src = '0;
	lost = 1'b0;
	fx = '0;
	avg = '0;
	sh = s.fast ? FAST_SHIFT : SLOW_SHIFT;

	// Holdover frequency averaging, one IIR step per tick.
	avg = 19'(s.acc >>> sh);
	next_s.tick_cnt = (s.tick_cnt >= AVG_TICK - 15'h1) ? '0 : s.tick_cnt + 15'h1;
	if (s.tick_cnt >= AVG_TICK - 15'h1) begin
		fx = 43'(signed'(cur_freq));
		next_s.acc = s.acc + fx - (s.acc >>> sh);
	end

	// Register writes. Out-of-range codes are ignored so the loop never sees them.
	if (reg_wr) begin
		case (reg_addr)
			A_GEN: next_s.ne_dis = reg_wdata[B_NE_DIS];
			A_IN0: next_s.in_8k[0] = reg_wdata[B_EIGHT_KHZ_DIVIDED_LOCK];
			A_IN1: next_s.in_8k[1] = reg_wdata[B_EIGHT_KHZ_DIVIDED_LOCK];
			A_IN2: next_s.in_8k[2] = reg_wdata[B_EIGHT_KHZ_DIVIDED_LOCK];
			A_IN3: next_s.in_8k[3] = reg_wdata[B_EIGHT_KHZ_DIVIDED_LOCK];
			A_AUTOBW: next_s.auto_bw = reg_wdata[B_AUTOBW];
			A_HOFS_L: next_s.hofs[7:0] = reg_wdata;
			A_HOFS_M: next_s.hofs[15:8] = reg_wdata;
			A_HMODE: begin
				next_s.hofs[18:16] = reg_wdata[2:0];
				next_s.fast = reg_wdata[B_FAST];
				next_s.rdavg = reg_wdata[B_RDAVG];
			end
			A_LOSS2: begin
				next_s.loss_en[2] = reg_wdata[B_LIMIT_EN];
				next_s.loss_en[3] = reg_wdata[B_ACT_EN];
			end
			A_LKBW: begin
				if (reg_wdata[3:0] < BW_STEPS) begin
					next_s.lk_bw = reg_wdata[3:0];
				end
			end
			A_ACQBW: begin
				if (reg_wdata[3:0] < BW_STEPS) begin
					next_s.acq_bw = reg_wdata[3:0];
				end
			end
			A_WT0: next_s.wt[7:0] = reg_wdata;
			A_DAMP: begin
				next_s.wt[15:8] = reg_wdata;
				if (reg_wdata[2:0] >= DAMP_MIN && reg_wdata[2:0] <= DAMP_MAX) begin
					next_s.damp = reg_wdata[2:0];
				end
			end
			A_WT0 + 8'h2: next_s.wt[23:16] = reg_wdata;
			A_WT0 + 8'h3: next_s.wt[31:24] = reg_wdata;
			A_LOSS1: next_s.loss_en[0] = reg_wdata[B_FINE_EN];
			A_MC: begin
				next_s.mc_en = reg_wdata[B_MC_EN];
				next_s.mc_full = reg_wdata[B_MC_FULL];
				next_s.loss_en[1] = reg_wdata[B_COARSE_EN];
				if (reg_wdata[3:0] <= MC_RNG_MAX) begin
					next_s.mc_rng = reg_wdata[3:0];
				end
			end
			A_OFS_L: next_s.ofs[7:0] = reg_wdata;
			A_OFS_H: next_s.ofs[15:8] = reg_wdata;
			A_AUXBW: begin
				if (reg_wdata[1:0] < AUX_STEPS) begin
					next_s.aux_bw = reg_wdata[1:0];
				end
			end
			A_FRANGE: begin
				if (reg_wdata[6:0] <= FRANGE_MAX && !reg_wdata[7]) begin
					next_s.frange = reg_wdata[6:0];
				end
			end
			A_FTOL: next_s.ftol = reg_wdata;
			A_DIV: next_s.div = reg_wdata;
			A_STS: begin
				if (reg_wdata[B_CLR_DISQ]) begin
					next_s.sts.disqualify = 1'b0;
				end
				if (reg_wdata[B_CLR_ALARM]) begin
					next_s.sts.alarm = 1'b0;
				end
			end
			default: ;
		endcase
	end

	// Inputs flagged for eight-kilohertz locking are divided before comparison.
	if (s.in_8k[ref_sel]) begin
		if (ref_edge) begin
			ref_e = (s.div_cnt >= s.div);
			next_s.div_cnt = ref_e ? '0 : s.div_cnt + 8'h1;
		end
	end else begin
		ref_e = ref_edge;
		next_s.div_cnt = '0;
	end

	// Fine detector: time between reference and feedback edges in sys_clk cycles.
	if (ref_e && fb_edge) begin
		next_s.fine = '0;
		next_s.ph_run = 1'b0;
	end else if (ref_e || fb_edge) begin
		if (!s.ph_run) begin
			next_s.ph_run = 1'b1;
			next_s.ph_dir = ref_e;
			// The opening cycle already counts, so a lag of n cycles reads as n.
			next_s.ph_cnt = 7'h1;
		end else begin
			next_s.ph_run = 1'b0;
			next_s.fine = s.ph_dir ? signed'({1'b0, s.ph_cnt}) : -signed'({1'b0, s.ph_cnt});
		end
	end else if (s.ph_run && s.ph_cnt != FINE_SAT) begin
		next_s.ph_cnt = s.ph_cnt + 7'h1;
	end

	// Cycle counter. Nearest-edge mode keeps no cycle count, so a missing pulse
	// is absorbed instead of being read as a slip; plain mode spans one cycle.
	lim_w = (16'h2 << s.mc_rng) - 16'h1;
	if (s.ctl.nearest_edge) begin
		lim = 14'sd0;
	end else if (s.mc_en) begin
		lim = signed'(lim_w[13:0]);
	end else begin
		lim = 14'sd1;
	end
	if (ref_e && !fb_edge && s.cyc < lim) begin
		next_s.cyc = s.cyc + 14'sd1;
	end else if (fb_edge && !ref_e && s.cyc > -lim) begin
		next_s.cyc = s.cyc - 14'sd1;
	end
	if (s.cyc > lim) begin
		next_s.cyc = lim;
	end else if (s.cyc < -lim) begin
		next_s.cyc = -lim;
	end

	// A source switch captures the standing phase so the output does not jump.
	next_s.sel_q = ref_sel;
	if (ref_sel != s.sel_q) begin
		next_s.phase_buildout = s.fine;
		next_s.cyc = '0;
	end
	resid = 9'(s.fine) - 9'(s.phase_buildout);
	if (s.mc_en && s.mc_full) begin
		next_s.sts.loop_phase = 22'({s.cyc, 8'h00}) + 22'(resid);
	end else begin
		next_s.sts.loop_phase = 22'(resid);
	end

	// Loss sources, each gated by its own enable.
	fine_abs = (s.fine < 0) ? -s.fine : s.fine;
	cyc_abs = (s.cyc < 0) ? -s.cyc : s.cyc;
	src[0] = (8'(fine_abs) > s.ftol);
	src[1] = s.mc_en && (cyc_abs >= signed'(lim_w[13:0]));
	src[2] = at_freq_limit;
	src[3] = !input_active;
	lost = |(src & s.loss_en);
	next_s.sts.lost = lost;
	next_s.sts.locked = !lost;

	// Long stays in lost-phase disqualify the source. Sets win over clears.
	if (lost) begin
		next_s.tmr = (s.tmr == 32'hffffffff) ? s.tmr : s.tmr + 32'h1;
		if (s.tmr >= LOST_LIMIT - 32'h1) begin
			next_s.sts.disqualify = 1'b1;
			next_s.sts.alarm = 1'b1;
		end
	end else begin
		next_s.tmr = '0;
	end

	// Lock state steers bandwidth choice and nearest-edge use.
	if (s.auto_bw) begin
		next_s.ctl.bw_sel = s.sts.locked ? s.lk_bw : s.acq_bw;
	end else begin
		next_s.ctl.bw_sel = s.lk_bw;
	end
	next_s.ctl.nearest_edge = s.sts.locked && !s.mc_en && !s.ne_dis;
	next_s.ctl.aux_bw = s.aux_bw;
	next_s.ctl.damping = s.damp;
	next_s.ctl.freq_range = s.frange;
	next_s.ctl.det_weight = s.wt;
	// The offset field is 16 bits wide, so it reaches +-32767 steps, a little short of
	// the full 200 ns. The limit is compared at int width so it is never read as negative.
	if (int'(s.ofs) > int'(OFS_MAX)) begin
		next_s.ctl.phase_offset = signed'(OFS_MAX);
	end else if (int'(s.ofs) < -int'(OFS_MAX)) begin
		next_s.ctl.phase_offset = -signed'(OFS_MAX);
	end else begin
		next_s.ctl.phase_offset = s.ofs;
	end

	// Read data stands only in the cycle after the read strobe.
	next_s.rdata = '0;
	if (reg_rd) begin
		case (reg_addr)
			A_GEN: next_s.rdata[B_NE_DIS] = s.ne_dis;
			A_IN0: next_s.rdata[B_EIGHT_KHZ_DIVIDED_LOCK] = s.in_8k[0];
			A_IN1: next_s.rdata[B_EIGHT_KHZ_DIVIDED_LOCK] = s.in_8k[1];
			A_IN2: next_s.rdata[B_EIGHT_KHZ_DIVIDED_LOCK] = s.in_8k[2];
			A_IN3: next_s.rdata[B_EIGHT_KHZ_DIVIDED_LOCK] = s.in_8k[3];
			A_AUTOBW: next_s.rdata[B_AUTOBW] = s.auto_bw;
			A_HOFS_L: next_s.rdata = s.rdavg ? avg[7:0] : s.hofs[7:0];
			A_HOFS_M: next_s.rdata = s.rdavg ? avg[15:8] : s.hofs[15:8];
			A_HMODE: begin
				next_s.rdata[2:0] = s.rdavg ? avg[18:16] : s.hofs[18:16];
				next_s.rdata[B_FAST] = s.fast;
				next_s.rdata[B_RDAVG] = s.rdavg;
			end
			A_LOSS2: begin
				next_s.rdata[B_LIMIT_EN] = s.loss_en[2];
				next_s.rdata[B_ACT_EN] = s.loss_en[3];
			end
			A_LKBW: next_s.rdata[3:0] = s.lk_bw;
			A_ACQBW: next_s.rdata[3:0] = s.acq_bw;
			A_WT0: next_s.rdata = s.wt[7:0];
			A_DAMP: next_s.rdata = {s.wt[15:11], s.damp};
			A_WT0 + 8'h2: next_s.rdata = s.wt[23:16];
			A_WT0 + 8'h3: next_s.rdata = s.wt[31:24];
			A_LOSS1: next_s.rdata[B_FINE_EN] = s.loss_en[0];
			A_MC: next_s.rdata = {s.loss_en[1], s.mc_en, s.mc_full, 1'b0, s.mc_rng};
			A_OFS_L: next_s.rdata = s.ofs[7:0];
			A_OFS_H: next_s.rdata = s.ofs[15:8];
			A_AUXBW: next_s.rdata[1:0] = s.aux_bw;
			A_FRANGE: next_s.rdata[6:0] = s.frange;
			A_FTOL: next_s.rdata = s.ftol;
			A_DIV: next_s.rdata = s.div;
			A_STS: begin
				next_s.rdata = {3'h0, s.sts.alarm, s.sts.disqualify,
					s.ctl.nearest_edge, s.sts.lost, s.sts.locked};
			end
			default: next_s.rdata = '0;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////

always_ff @(posedge sys_clk or negedge resetn) begin
	if (!resetn) begin
		s <= '0;
		s.lk_bw <= RST_LK_BW;
		s.acq_bw <= RST_ACQ_BW;
		s.damp <= RST_DAMP;
		s.wt <= {4{RST_WT}};
		s.frange <= RST_FRANGE;
		s.ftol <= RST_FTOL;
		s.div <= RST_DIV;
		s.ctl.bw_sel <= RST_LK_BW;
		s.ctl.damping <= RST_DAMP;
		s.ctl.freq_range <= RST_FRANGE;
		s.ctl.det_weight <= {4{RST_WT}};
	end else begin
		s <= next_s;
	end
end

endmodule

// >>> testbench/dpl_monitor.sv
// Port-level assertions for the digital PLL phase and bandwidth control core.
`timescale 1ns/1ps
module dpl_monitor
	import dpl_pkg::*;
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire dpl_ctl_t ctl,
	input wire dpl_sts_t sts
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	a_read_data_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its slot");
	a_lock_loss_excl: assert property (sts.locked |-> !sts.lost)
		else $error("locked and lost together");
	a_edge_needs_lock: assert property (ctl.nearest_edge |-> $past(sts.locked))
		else $error("nearest edge without lock");
	a_main_bw_legal: assert property (ctl.bw_sel < BW_STEPS)
		else $error("main bandwidth step out of range");
	a_damp_code_legal: assert property (ctl.damping >= DAMP_MIN && ctl.damping <= DAMP_MAX)
		else $error("damping code out of range");
	a_aux_bw_legal: assert property (ctl.aux_bw < AUX_STEPS)
		else $error("auxiliary bandwidth illegal");
	a_frange_legal: assert property (ctl.freq_range <= FRANGE_MAX)
		else $error("frequency range above limit");
	a_alarm_sticky: assert property (sts.alarm && !(reg_wr && reg_addr == A_STS
		&& reg_wdata[B_CLR_ALARM]) |=> sts.alarm)
		else $error("alarm dropped without clear");
	a_disq_after_lost: assert property ($rose(sts.disqualify) |-> $past(sts.lost))
		else $error("disqualify without lost phase");
	c_lost: cover property ($rose(sts.lost));
	c_edge: cover property ($rose(ctl.nearest_edge));
	c_alarm: cover property ($rose(sts.alarm));
endmodule
bind dpl_core dpl_monitor u_mon (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.ctl(ctl), .sts(sts));

// >>> testbench/dpl_edge_model.sv
// Reference and feedback edge source standing in for the selected input and the synthesizer.
`timescale 1ns/1ps
module dpl_edge_model #(
	parameter int PERIOD = 12
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [3:0] lag,
	output logic ref_edge,
	output logic fb_edge
);
	int cnt;
	logic [3:0] lag_q;
	// Feedback trails the reference by lag cycles, so the fine phase equals lag.
	// A new lag waits for the next period, so no feedback edge is lost or doubled.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cnt <= 0;
			lag_q <= 4'h0;
			ref_edge <= 1'b0;
			fb_edge <= 1'b0;
		end else begin
			cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
			if (cnt == PERIOD - 1) begin
				lag_q <= lag;
			end
			ref_edge <= (cnt == 0);
			fb_edge <= (cnt == int'(lag_q));
		end
	end
endmodule

// >>> testbench/test_dpll_phase_detect_bw_control.sv
// Register-level testbench of the digital PLL phase and bandwidth control core.
`timescale 1ns/1ps
module test_dpll_phase_detect_bw_control
	import dpl_pkg::*;
;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic at_freq_limit = 1'b0;
	logic input_active = 1'b1;
	logic [3:0] lag = 4'h1;
	logic [1:0] ref_sel = 2'b00;
	logic ref_edge;
	logic fb_edge;
	dpl_ctl_t ctl;
	dpl_sts_t sts;
	int mismatches = 0;
	int total_checks = 0;
	int cycles = 0;
	logic [7:0] tbl [4][3] = '{'{A_LKBW, 8'h0a, 8'h09}, '{A_ACQBW, 8'h0b, 8'h00},
		'{A_AUXBW, 8'h03, 8'h02}, '{A_FRANGE, 8'h51, 8'h50}};
	logic [7:0] rst_val [4] = '{8'h04, 8'h07, 8'h00, 8'h09};
	logic [2:0] dexp;

	always #20 sys_clk = ~sys_clk;

	// The lost-phase limit is shortened so disqualification shows within a short run.
	dpl_core #(.LOST_LIMIT(32'd50), .AVG_TICK(15'd4)) uut (.sys_clk(sys_clk), .resetn(resetn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .ref_sel(ref_sel), .ref_edge(ref_edge), .fb_edge(fb_edge),
		.cur_freq(19'h00000), .at_freq_limit(at_freq_limit), .input_active(input_active),
		.ctl(ctl), .sts(sts));
	dpl_edge_model #(.PERIOD(12)) u_edges (.sys_clk(sys_clk), .resetn(resetn), .lag(lag),
		.ref_edge(ref_edge), .fb_edge(fb_edge));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data are sampled mid-cycle because they stand for one cycle only.
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		check($sformatf("reg %h", a), reg_rdata, exp);
	endtask

	task automatic wait_lost(input logic v);
		for (int i = 0; i < 100 && sts.lost !== v; i++) @(posedge sys_clk);
		check("lost", sts.lost, v);
	endtask

	task automatic settle();
		repeat (4) @(posedge sys_clk);
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// A run needs well under two thousand cycles; the ceiling leaves ample margin.
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			report_and_stop();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		settle();
		rd(A_WT0, 8'h40);
		check("weight", ctl.det_weight, 32'h40404040);
		rd(8'h01, 8'h00);
		rd(A_STS, 8'h05);
		for (int i = 0; i < 4; i++) begin
			wr(tbl[i][0], tbl[i][1]);
			rd(tbl[i][0], rst_val[i]);
			wr(tbl[i][0], tbl[i][2]);
			rd(tbl[i][0], tbl[i][2]);
		end
		check("aux bw", ctl.aux_bw, 2'd2);
		check("freq range", ctl.freq_range, 7'd80);
		dexp = 3'd3;
		for (int d = 0; d < 8; d++) begin
			wr(A_DAMP, {5'h08, 3'(d)});
			if (d >= 1 && d <= 5) dexp = 3'(d);
			rd(A_DAMP, {5'h08, dexp});
			check("damping", ctl.damping, dexp);
		end
		wr(A_HOFS_L, 8'h5a);
		rd(A_HOFS_L, 8'h5a);
		wr(A_HMODE, 8'h20);
		rd(A_HOFS_L, 8'h00);
		rd(A_HMODE, 8'h20);
		wr(A_OFS_L, 8'h35);
		wr(A_OFS_H, 8'h82);
		settle();
		check("offset", ctl.phase_offset, 16'sh8235);
		wr(A_LKBW, 8'h02);
		wr(A_ACQBW, 8'h08);
		settle();
		check("bw locked", ctl.bw_sel, 4'd2);
		wr(A_FTOL, 8'h02);
		wr(A_LOSS1, 8'h01);
		lag <= 4'h5;
		wait_lost(1'b1);
		settle();
		check("bw manual", ctl.bw_sel, 4'd2);
		wr(A_AUTOBW, 8'h01);
		settle();
		check("bw acq", ctl.bw_sel, 4'd8);
		check("edge off", ctl.nearest_edge, 1'b0);
		for (int i = 0; i < 100 && sts.disqualify !== 1'b1; i++) @(posedge sys_clk);
		check("alarm", sts.alarm, 1'b1);
		check("disqualify", sts.disqualify, 1'b1);
		lag <= 4'h1;
		wait_lost(1'b0);
		settle();
		check("bw lock", ctl.bw_sel, 4'd2);
		check("fine phase", sts.loop_phase, 22'h1);
		ref_sel <= 2'b01;
		settle();
		check("buildout", sts.loop_phase, 22'h0);
		wr(A_STS, 8'h18);
		rd(A_STS, 8'h05);
		wr(A_GEN, 8'h40);
		settle();
		check("edge barred", ctl.nearest_edge, 1'b0);
		wr(A_GEN, 8'h00);
		settle();
		check("edge back", ctl.nearest_edge, 1'b1);
		wr(A_MC, 8'h40);
		settle();
		check("edge mc", ctl.nearest_edge, 1'b0);
		wr(A_MC, 8'h00);
		wr(A_LOSS2, 8'h02);
		input_active <= 1'b0;
		wait_lost(1'b1);
		wr(A_LOSS2, 8'h00);
		wait_lost(1'b0);
		input_active <= 1'b1;
		at_freq_limit <= 1'b1;
		settle();
		check("limit off", sts.lost, 1'b0);
		wr(A_LOSS2, 8'h01);
		wait_lost(1'b1);
		at_freq_limit <= 1'b0;
		wait_lost(1'b0);
		wr(A_DIV, 8'h01);
		wr(A_IN1, 8'h40);
		rd(A_IN1, 8'h40);
		wait_lost(1'b1);
		report_and_stop();
	end
endmodule
